// [inc/supply_integrity_pkg.sv]
package supply_integrity_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned WAKEUP_NS = 33_000;
  localparam int unsigned WAKEUP_CYC = (WAKEUP_NS * (CLK_HZ / 1_000_000)) / 1_000;
  localparam int unsigned EXT_CLK_MIN_HZ = 10_000_000;
  localparam logic [7:0] CSR_INDEX = 8'h3A;
  localparam logic [7:0] THR_INDEX = 8'h3E;
  localparam logic [9:0] CSR_ADDR = {CSR_INDEX, 2'b00};
  localparam logic [9:0] THR_ADDR = {THR_INDEX, 2'b00};
  localparam int unsigned CSR_IRQ_EN_BIT = 0;
  localparam int unsigned CSR_WARN_BIT = 1;
  localparam int unsigned CSR_FLAG_BIT = 2;
  localparam int unsigned CSR_TRIM_LSB = 5;
  localparam int unsigned THR_SEL_LSB = 0;
  localparam logic [1:0] TRIM_RESET = 2'h0;
  localparam logic [1:0] WARN_SEL_RESET = 2'h3;
  localparam logic [1:0] WARN_SEL_OFF = 2'h3;
endpackage : supply_integrity_pkg

// [hdl/sync_pair.sv]
`timescale 1ns/1ns
`default_nettype none
module sync_pair #(
  parameter int unsigned WIDTH = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;

  if (WIDTH < 1) begin : g_bad_width
    $error("sync_pair needs at least one bit");
  end

  // Only the second stage is visible; the first may be metastable.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : sync_pair
`default_nettype wire

// [hdl/supply_integrity_monitor.sv]
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module supply_integrity_monitor
  import supply_integrity_pkg::*;
#(
  parameter int unsigned ADDR_W = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic below_upper_ref,
  input wire logic below_lower_ref,
  input wire logic warn_cmp,
  input wire logic opt_drop_enable,
  input wire logic [1:0] opt_drop_level,
  input wire logic ext_clock_sel,
  input wire logic ext_clock_fast,
  input wire logic wait_mode,
  input wire logic halt_mode,
  input wire logic core_irq_mask,
  input wire logic irq_ack,
  input wire logic illegal_op_req,
  output logic [1:0] drop_level_sel,
  output logic [1:0] warn_level_sel,
  output logic warn_detector_on,
  output logic [1:0] osc_trim_low,
  output logic chip_reset,
  output logic reset_pin_out,
  output logic reset_pin_oe_n,
  output logic wdg_flag_clear,
  output logic warn_irq,
  output logic wake_req
);
  logic [2:0] sync_q;
  logic upper_s, lower_s, warn_s, warn_prev_r;
  logic drop_active_r, drop_prev_r, supply_reset_flag_r, warning_irq_enable_r;
  logic [1:0] trim_r, warn_sel_r;
  logic irq_pend_r, pend_nxt;
  logic [$clog2(WAKEUP_CYC+1)-1:0] dip_cnt_r;
  logic acc, wr_en, rd_en, hit_csr, hit_thr, flag_set, warn_edge;

  if (ADDR_W < 10) begin : g_bad_addr
    $error("supply_integrity_monitor needs ADDR_W of at least 10");
  end

  function automatic logic [7:0] csr_image(input logic en, input logic warn,
                                           input logic flag, input logic [1:0] trim);
    csr_image = '0;
    csr_image[CSR_IRQ_EN_BIT] = en;
    csr_image[CSR_WARN_BIT] = warn;
    csr_image[CSR_FLAG_BIT] = flag;
    csr_image[CSR_TRIM_LSB +: 2] = trim;
  endfunction : csr_image

  sync_pair #(.WIDTH(3)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({below_upper_ref, below_lower_ref, warn_cmp}),
    .q(sync_q)
  );
  assign {upper_s, lower_s, warn_s} = sync_q;

  assign acc = psel && penable && pready;
  // Halt freezes the register: bus writes and read-clears have no effect there.
  assign wr_en = acc && pwrite && !halt_mode;
  assign rd_en = acc && !pwrite && !halt_mode;
  assign hit_csr = (paddr == ADDR_W'(CSR_ADDR));
  assign hit_thr = (paddr == ADDR_W'(THR_ADDR));

  // Hysteresis from two comparators; a gap between them holds the state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drop_active_r <= 1'b0;
      drop_prev_r <= 1'b0;
    end else begin
      drop_prev_r <= drop_active_r;
      if (!opt_drop_enable) begin
        drop_active_r <= 1'b0;
      end else if (lower_s) begin
        drop_active_r <= 1'b1;
      end else if (!upper_s) begin
        drop_active_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chip_reset <= 1'b0;
      reset_pin_out <= 1'b1;
      reset_pin_oe_n <= 1'b1;
      wdg_flag_clear <= 1'b0;
      drop_level_sel <= 2'h0;
    end else begin
      chip_reset <= drop_active_r || illegal_op_req;
      reset_pin_out <= 1'b0;
      reset_pin_oe_n <= !drop_active_r;
      wdg_flag_clear <= drop_active_r && !drop_prev_r;
      drop_level_sel <= opt_drop_level;
    end
  end

  // Dip length decides whether the internal-clock flag can be recorded.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dip_cnt_r <= '0;
    end else if (!drop_active_r) begin
      dip_cnt_r <= '0;
    end else if (dip_cnt_r != WAKEUP_CYC[$bits(dip_cnt_r)-1:0]) begin
      dip_cnt_r <= dip_cnt_r + 1'b1;
    end
  end

  assign flag_set = drop_active_r && !halt_mode && (ext_clock_sel
                    ? (ext_clock_fast && !drop_prev_r)
                    : (dip_cnt_r == WAKEUP_CYC[$bits(dip_cnt_r)-1:0] - 1'b1));

  // Only presetn, the supply detector and a register read touch the flag, so other resets keep it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_reset_flag_r <= 1'b0;
    end else if (flag_set) begin
      supply_reset_flag_r <= 1'b1;
    end else if (rd_en && hit_csr) begin
      supply_reset_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warning_irq_enable_r <= 1'b0;
      trim_r <= TRIM_RESET;
      warn_sel_r <= WARN_SEL_RESET;
    end else if (wr_en && hit_csr) begin
      warning_irq_enable_r <= pwdata[CSR_IRQ_EN_BIT];
      trim_r <= pwdata[CSR_TRIM_LSB +: 2];
    end else if (wr_en && hit_thr) begin
      warn_sel_r <= pwdata[THR_SEL_LSB +: 2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_level_sel <= WARN_SEL_RESET;
      warn_detector_on <= 1'b0;
      osc_trim_low <= TRIM_RESET;
    end else begin
      warn_level_sel <= warn_sel_r;
      warn_detector_on <= (warn_sel_r != WARN_SEL_OFF);
      osc_trim_low <= trim_r;
    end
  end

  // Both crossing directions count; set wins over the acknowledge.
  assign warn_edge = warn_detector_on && (warn_s != warn_prev_r);
  always_comb begin
    pend_nxt = irq_pend_r;
    if (irq_ack) begin
      pend_nxt = 1'b0;
    end
    if (warn_edge && warning_irq_enable_r) begin
      pend_nxt = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_prev_r <= 1'b0;
      irq_pend_r <= 1'b0;
      warn_irq <= 1'b0;
      wake_req <= 1'b0;
    end else begin
      warn_prev_r <= warn_s;
      irq_pend_r <= pend_nxt;
      warn_irq <= pend_nxt && warning_irq_enable_r && !core_irq_mask;
      wake_req <= pend_nxt && warning_irq_enable_r && wait_mode && !halt_mode;
    end
  end

  // No wait state: pready rises in the first access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(hit_csr || hit_thr);
      prdata <= '0;
      if (psel && !penable && hit_csr) begin
        // The flag reads zero while the detector is off; its value then means nothing.
        prdata[7:0] <= csr_image(warning_irq_enable_r, warn_s,
                                 supply_reset_flag_r && opt_drop_enable, trim_r);
      end else if (psel && !penable && hit_thr) begin
        prdata[THR_SEL_LSB +: 2] <= warn_sel_r;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_drop_sets;
    opt_drop_enable && lower_s ##1 opt_drop_enable |-> drop_active_r;
  endproperty
  a_drop_sets: assert property (p_drop_sets) else $error("drop reset not entered");

  property p_hyst_hold;
    drop_active_r && upper_s && opt_drop_enable |=> drop_active_r;
  endproperty
  a_hyst_hold: assert property (p_hyst_hold) else $error("drop released early");

  property p_chip_reset;
    drop_active_r |=> chip_reset && !reset_pin_oe_n && !reset_pin_out;
  endproperty
  a_chip_reset: assert property (p_chip_reset) else $error("reset not held");

  property p_disabled;
    !opt_drop_enable |=> !drop_active_r;
  endproperty
  a_disabled: assert property (p_disabled) else $error("drop reset while disabled");

  property p_wdg_clear;
    $rose(drop_active_r) |=> wdg_flag_clear ##1 !wdg_flag_clear;
  endproperty
  a_wdg_clear: assert property (p_wdg_clear) else $error("watchdog flag clear missing");

  property p_read_clear;
    rd_en && hit_csr && !flag_set |=> !supply_reset_flag_r;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("flag not cleared by read");

  property p_flag_halt;
    halt_mode && !supply_reset_flag_r |=> !supply_reset_flag_r;
  endproperty
  a_flag_halt: assert property (p_flag_halt) else $error("flag set during halt");

  property p_irq_gate;
    warn_irq |-> $past(warning_irq_enable_r) && !$past(core_irq_mask);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq delivered while gated");

  property p_no_halt_wake;
    halt_mode |=> !wake_req;
  endproperty
  a_no_halt_wake: assert property (p_no_halt_wake) else $error("wake during halt");

  property p_edge_pend;
    warn_edge && warning_irq_enable_r |=> irq_pend_r;
  endproperty
  a_edge_pend: assert property (p_edge_pend) else $error("crossing lost");
endmodule : supply_integrity_monitor
`default_nettype wire

// [test/supply_env_model.sv]
`timescale 1ns/1ns
`default_nettype none
module supply_env_model #(
  parameter logic [7:0] LOWER = 8'h20,
  parameter logic [7:0] UPPER = 8'h28,
  parameter logic [7:0] WARN = 8'h40
) (
  input wire logic pclk,
  input wire logic [7:0] vdd,
  input wire logic warn_irq,
  output logic below_upper_ref,
  output logic below_lower_ref,
  output logic warn_cmp,
  output logic irq_ack
);
  logic [1:0] cnt_r = 2'h0;
  // The two references differ, so the reset window shows hysteresis.
  assign below_upper_ref = vdd < UPPER;
  assign below_lower_ref = vdd < LOWER;
  assign warn_cmp = vdd < WARN;
  // The core takes the vector a few cycles late, as a real fetch would.
  always @(posedge pclk) begin
    cnt_r <= warn_irq ? cnt_r + 2'h1 : 2'h0;
  end
  assign irq_ack = warn_irq && cnt_r == 2'h3;
endmodule : supply_env_model
`default_nettype wire

// [test/supply_integrity_monitor_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module supply_integrity_monitor_tb_top;
  import supply_integrity_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic pready, pslverr, e, bu, bl, wc, ack, en = 1'b1, ecs = 1'b0, ecf = 1'b0;
  logic wm = 1'b0, hm = 1'b0, msk = 1'b0, ill = 1'b0, wfc, wirq, wake, crst, rpo, oe_n, wdon;
  logic [1:0] lvl = 2'h0, dls, wls, trim;
  logic [7:0] vdd = 8'h50;
  int miscompares = 0, samples_checked = 0, cyc = 0, wdg_n = 0, n;
  always #5 pclk = ~pclk;
  supply_integrity_monitor DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .below_upper_ref(bu), .below_lower_ref(bl),
    .warn_cmp(wc), .opt_drop_enable(en), .opt_drop_level(lvl), .ext_clock_sel(ecs),
    .ext_clock_fast(ecf), .wait_mode(wm), .halt_mode(hm), .core_irq_mask(msk),
    .irq_ack(ack), .illegal_op_req(ill), .drop_level_sel(dls), .warn_level_sel(wls),
    .warn_detector_on(wdon), .osc_trim_low(trim), .chip_reset(crst), .reset_pin_out(rpo),
    .reset_pin_oe_n(oe_n), .wdg_flag_clear(wfc), .warn_irq(wirq), .wake_req(wake));
  supply_env_model ENV (.pclk(pclk), .vdd(vdd), .warn_irq(wirq), .below_upper_ref(bu),
    .below_lower_ref(bl), .warn_cmp(wc), .irq_ack(ack));
  task automatic close_out;
    if (miscompares == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk
  // The request stays put until pready is sampled high.
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wt(input int c);
    repeat (c) @(posedge pclk);
  endtask : wt
  task automatic dip(input int c);
    vdd <= 8'h10;
    wt(c);
    vdd <= 8'h50;
    wt(10);
  endtask : dip
  always @(posedge pclk) begin
    cyc++;
    if (wfc === 1'b1) wdg_n++;
    if (cyc > 20000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    wt(10);
    presetn <= 1'b1;
    wt(2);
    apb(1, CSR_ADDR, 32'h0000_0063);
    apb(0, THR_ADDR, 0); chk(q, 32'h0000_0003);
    apb(0, 10'h000, 0); chk({31'h0, e}, 32'h0000_0001);
    for (int i = 0; i < 3; i++) begin
      lvl <= i[1:0];
      wt(3); chk({30'h0, dls}, i);
    end
    apb(0, CSR_ADDR, 0); chk(q, 32'h0000_0061);
    chk({30'h0, trim}, 32'h0000_0003);
    apb(1, THR_ADDR, 0);
    wt(1); chk({29'h0, wdon, wls}, 32'h0000_0004);
    msk <= 1'b1;
    wm <= 1'b1;
    vdd <= 8'h30;
    wt(10); chk({31'h0, wirq}, 0);
    apb(0, CSR_ADDR, 0); chk(q, 32'h0000_0063);
    msk <= 1'b0;
    for (n = 0; n < 12 && wirq !== 1'b1; n++) @(posedge pclk);
    chk({30'h0, wirq, wake}, 32'h0000_0003);
    wt(10); chk({31'h0, wirq}, 0);
    vdd <= 8'h50;
    for (n = 0; n < 12 && wirq !== 1'b1; n++) @(posedge pclk);
    chk({31'h0, wirq}, 1);
    wm <= 1'b0;
    hm <= 1'b1;
    apb(1, CSR_ADDR, 0);
    apb(0, CSR_ADDR, 0); chk(q, 32'h0000_0061);
    hm <= 1'b0;
    vdd <= 8'h24;
    wt(10); chk({31'h0, crst}, 0);
    en <= 1'b0;
    vdd <= 8'h10;
    wt(10); chk({31'h0, crst}, 0);
    vdd <= 8'h50;
    wt(10);
    en <= 1'b1;
    wt(10);
    vdd <= 8'h10;
    wt(WAKEUP_CYC + 100); chk({30'h0, crst, oe_n}, 32'h0000_0002);
    chk(wdg_n, 1);
    vdd <= 8'h24;
    wt(10); chk({31'h0, crst}, 1);
    vdd <= 8'h50;
    wt(10); chk({31'h0, crst}, 0);
    apb(0, CSR_ADDR, 0); chk(q & 32'h0000_0004, 32'h0000_0004);
    apb(0, CSR_ADDR, 0); chk(q & 32'h0000_0004, 0);
    ill <= 1'b1;
    wt(5); chk({30'h0, crst, rpo}, 32'h0000_0002);
    ill <= 1'b0;
    wt(5);
    dip(20);
    apb(0, CSR_ADDR, 0); chk(q & 32'h0000_0004, 0);
    ecs <= 1'b1;
    ecf <= 1'b1;
    dip(20);
    apb(0, CSR_ADDR, 0); chk(q & 32'h0000_0004, 32'h0000_0004);
    dip(20);
    en <= 1'b0;
    apb(0, CSR_ADDR, 0); chk(q & 32'h0000_0004, 0);
    en <= 1'b1;
    hm <= 1'b1;
    dip(20);
    hm <= 1'b0;
    apb(0, CSR_ADDR, 0); chk(q & 32'h0000_0004, 0);
    ecf <= 1'b0;
    dip(20);
    apb(0, CSR_ADDR, 0); chk(q & 32'h0000_0004, 0);
    chk(wdg_n, 6);
    close_out();
  end
endmodule : supply_integrity_monitor_tb_top
`default_nettype wire
